//--- rtl/csr_map_defines.vh
// Register offsets, reset values and access constants of the CSR map
`ifndef CSR_MAP_DEFINES_VH
`define CSR_MAP_DEFINES_VH

`define ADDR_W 17
`define OFS_DEVICE_CONTROL 17'h00000
`define OFS_DEVICE_CONTROL_ALIAS 17'h00004
`define OFS_DEVICE_STATE 17'h00008
`define OFS_NVM_FLASH_CONTROL 17'h00010
`define OFS_NVM_READ_REQUEST 17'h00014
`define OFS_EXTENDED_DEVICE_CONTROL 17'h00018
`define OFS_FLASH_DIRECT_ACCESS 17'h0001C
`define OFS_PHY_MANAGEMENT_CONTROL 17'h00020
`define OFS_PAUSE_ADDRESS_LOW 17'h00028
`define OFS_PAUSE_ADDRESS_HIGH 17'h0002C
`define OFS_PAUSE_FRAME_TYPE 17'h00030
`define OFS_VLAN_ETHERTYPE_VALUE 17'h00038
`define OFS_PAUSE_TRANSMIT_TIMER 17'h00170
`define OFS_INDICATOR_LIGHT_CONTROL 17'h00E00
`define OFS_EXT_CONFIG_CONTROL 17'h00F00
`define OFS_EXT_CONFIG_SIZE 17'h00F08
`define OFS_PACKET_BUFFER_SPLIT 17'h01000
`define OFS_MGMT_NVM_CONTROL 17'h01010
`define OFS_MGMT_NVM_RW_DATA 17'h01014
`define OFS_MGMT_FLASH_CONTROL 17'h01018
`define OFS_MGMT_FLASH_READ_DATA 17'h0101C
`define OFS_MGMT_FLASH_READ_COUNT 17'h01020
`define OFS_FLASH_TIMING 17'h01028
`define OFS_NVM_WRITE_REQUEST 17'h0102C
`define OFS_SW_FLASH_BURST_CONTROL 17'h01030
`define OFS_SW_FLASH_BURST_DATA 17'h01034
`define OFS_SW_FLASH_BURST_COUNT 17'h01038
`define OFS_FLASH_OPCODE_SELECT 17'h0103C
`define OFS_FLASH_AUTO_LOAD 17'h01050
`define OFS_HOST_LINK_CONTROL 17'h05B00
`define OFS_FUNCTION_TAG 17'h05B08
`define OFS_LINK_STAT_CONTROL_1 17'h05B10
`define OFS_LINK_STAT_CONTROL_2 17'h05B14
`define OFS_LINK_STAT_CONTROL_3 17'h05B18
`define OFS_LINK_STAT_CONTROL_4 17'h05B1C
`define OFS_LINK_STAT_COUNTER_0 17'h05B20
`define OFS_LINK_STAT_COUNTER_1 17'h05B24
`define OFS_PAUSE_REFRESH_THRESHOLD 17'h05F40
`define OFS_INTERRUPT_CAUSE_LATCH 17'h000C0

`define BE_ALL 4'hF
`define RST_VALUE 32'h00000000
`define RD_UNMAPPED 32'h00000000
`define STAT_CNT_W 64
`define CTRL_RESET_BIT 26
`define STATE_LINK_BIT 1
`define STATE_NVM_BIT 8

`endif

//--- rtl/csr_word_reg.v
// One 32-bit CSR word with full-dword write qualification and override loads
`timescale 1ns/1ns
`default_nettype none
`include "csr_map_defines.vh"

module csr_word_reg
#(
   parameter [31:0] RESET_VALUE = `RST_VALUE
)
(
   input wire clk_sys,
   input wire rst_n,
   input wire wr_sel,
   input wire [3:0] wr_be,
   input wire [31:0] wr_data,
   input wire nvm_load,
   input wire [31:0] nvm_data,
   input wire hw_load,
   input wire [31:0] hw_data,
   input wire mirror_load,
   input wire [31:0] mirror_data,
   output reg [31:0] q_ff
);

   reg [31:0] nxt_q;

   always @*
   begin
      nxt_q = q_ff;
      // Host write only with all four lanes; partial write dropped
      if (wr_sel && (wr_be == `BE_ALL))
      begin
         nxt_q = wr_data;
      end
      // Superseding events override the host write; NVM load wins over hardware and mirror loads
      if (mirror_load)
      begin
         nxt_q = mirror_data;
      end
      if (hw_load)
      begin
         nxt_q = hw_data;
      end
      if (nvm_load)
      begin
         nxt_q = nvm_data;
      end
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q_ff <= RESET_VALUE;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

endmodule // csr_word_reg

`default_nettype wire

//--- rtl/csr_access_conventions_map.v
// CSR space decode, access-size conventions and general register bank
`timescale 1ns/1ns
`default_nettype none
`include "csr_map_defines.vh"

module csr_access_conventions_map
#(
   parameter ADDR_W = `ADDR_W,
   parameter STAT_W = `STAT_CNT_W
)
(
   input wire clk_sys,
   input wire arst_n,
   // CSR memory space access
   input wire csr_req,
   input wire csr_wr,
   input wire [ADDR_W-1:0] csr_addr,
   input wire [3:0] csr_be,
   input wire [31:0] csr_wdata,
   output reg csr_ack_ff,
   output reg [31:0] csr_rdata_ff,
   // Flash window access (ROM, second BAR or I/O space)
   input wire flash_req,
   input wire flash_wr,
   input wire [23:0] flash_addr,
   input wire [3:0] flash_be,
   input wire [31:0] flash_wdata,
   output reg flash_ack_ff,
   output reg [31:0] flash_rdata_ff,
   output reg flash_cmd_ff,
   output reg flash_cmd_wr_ff,
   output reg [23:0] flash_cmd_addr_ff,
   output reg [3:0] flash_cmd_be_ff,
   output reg [31:0] flash_cmd_data_ff,
   input wire flash_rsp_valid,
   input wire [31:0] flash_rsp_data,
   // Superseding events from core
   input wire nvm_load_valid,
   input wire [ADDR_W-1:0] nvm_load_addr,
   input wire [31:0] nvm_load_data,
   input wire autoneg_done,
   input wire [31:0] autoneg_ctrl_value,
   // Core state and events
   input wire link_up,
   input wire nvm_present,
   input wire [31:0] cause_set,
   input wire stat_event,
   // Core controls
   output wire [31:0] device_control,
   output wire [31:0] extended_device_control,
   output wire [31:0] packet_buffer_split,
   output wire sw_reset
);

   // ******************************
   // Reset release
   // ******************************
   reg rst_meta_ff;
   reg rst_ff;

   always @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_meta_ff <= 1'b0;
         rst_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_ff <= rst_meta_ff;
      end
   end

   // ******************************
   // Decode
   // ******************************
   localparam NREG = 36;
   localparam [5:0] I_CTRL = 6'd0;
   localparam [5:0] I_EXT = 6'd4;
   localparam [5:0] I_PBA = 6'd15;
   localparam [5:0] I_NONE = 6'd63;

   function [5:0] reg_index;
      input [ADDR_W-1:0] a;
      begin
         if (a == `OFS_DEVICE_CONTROL || a == `OFS_DEVICE_CONTROL_ALIAS) reg_index = 6'd0;
         else if (a == `OFS_NVM_FLASH_CONTROL) reg_index = 6'd1;
         else if (a == `OFS_NVM_READ_REQUEST) reg_index = 6'd2;
         else if (a == `OFS_FLASH_DIRECT_ACCESS) reg_index = 6'd3;
         else if (a == `OFS_EXTENDED_DEVICE_CONTROL) reg_index = 6'd4;
         else if (a == `OFS_PHY_MANAGEMENT_CONTROL) reg_index = 6'd5;
         else if (a == `OFS_PAUSE_ADDRESS_LOW) reg_index = 6'd6;
         else if (a == `OFS_PAUSE_ADDRESS_HIGH) reg_index = 6'd7;
         else if (a == `OFS_PAUSE_FRAME_TYPE) reg_index = 6'd8;
         else if (a == `OFS_VLAN_ETHERTYPE_VALUE) reg_index = 6'd9;
         else if (a == `OFS_PAUSE_TRANSMIT_TIMER) reg_index = 6'd10;
         else if (a == `OFS_PAUSE_REFRESH_THRESHOLD) reg_index = 6'd11;
         else if (a == `OFS_INDICATOR_LIGHT_CONTROL) reg_index = 6'd12;
         else if (a == `OFS_EXT_CONFIG_CONTROL) reg_index = 6'd13;
         else if (a == `OFS_EXT_CONFIG_SIZE) reg_index = 6'd14;
         else if (a == `OFS_PACKET_BUFFER_SPLIT) reg_index = 6'd15;
         else if (a == `OFS_MGMT_NVM_CONTROL) reg_index = 6'd16;
         else if (a == `OFS_MGMT_NVM_RW_DATA) reg_index = 6'd17;
         else if (a == `OFS_MGMT_FLASH_CONTROL) reg_index = 6'd18;
         else if (a == `OFS_MGMT_FLASH_READ_DATA) reg_index = 6'd19;
         else if (a == `OFS_MGMT_FLASH_READ_COUNT) reg_index = 6'd20;
         else if (a == `OFS_FLASH_TIMING) reg_index = 6'd21;
         else if (a == `OFS_NVM_WRITE_REQUEST) reg_index = 6'd22;
         else if (a == `OFS_SW_FLASH_BURST_CONTROL) reg_index = 6'd23;
         else if (a == `OFS_SW_FLASH_BURST_DATA) reg_index = 6'd24;
         else if (a == `OFS_SW_FLASH_BURST_COUNT) reg_index = 6'd25;
         else if (a == `OFS_FLASH_OPCODE_SELECT) reg_index = 6'd26;
         else if (a == `OFS_FLASH_AUTO_LOAD) reg_index = 6'd27;
         else if (a == `OFS_HOST_LINK_CONTROL) reg_index = 6'd28;
         else if (a == `OFS_FUNCTION_TAG) reg_index = 6'd29;
         else if (a == `OFS_LINK_STAT_CONTROL_1) reg_index = 6'd30;
         else if (a == `OFS_LINK_STAT_CONTROL_2) reg_index = 6'd31;
         else if (a == `OFS_LINK_STAT_CONTROL_3) reg_index = 6'd32;
         else if (a == `OFS_LINK_STAT_CONTROL_4) reg_index = 6'd33;
         else if (a == `OFS_LINK_STAT_COUNTER_0) reg_index = 6'd34;
         else if (a == `OFS_LINK_STAT_COUNTER_1) reg_index = 6'd35;
         else reg_index = I_NONE;
      end
   endfunction

   // Read-only registers fed by core, not by host writes
   function is_ro;
      input [5:0] i;
      begin
         is_ro = (i >= 6'd16 && i <= 6'd20);
      end
   endfunction

   wire [5:0] acc_idx = reg_index(csr_addr);
   wire is_state = (csr_addr == `OFS_DEVICE_STATE);
   wire is_cause = (csr_addr == `OFS_INTERRUPT_CAUSE_LATCH);
   wire dword_wr = csr_req && csr_wr && (csr_be == `BE_ALL);

   // ******************************
   // Register words
   // ******************************
   wire [32*NREG-1:0] word_bus;
   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1)
      begin : g_word
         wire sel = csr_req && csr_wr && (acc_idx == g) && !is_ro(g);
         wire nvm_hit = nvm_load_valid && (reg_index(nvm_load_addr) == g);
         // Control word also takes the negotiated result and bit 0 of extended control when a dword write sets it
         wire hw_hit = (g == I_CTRL) && autoneg_done;
         wire mir_hit = (g == I_CTRL) && dword_wr && (acc_idx == I_EXT);
         csr_word_reg #(
            .RESET_VALUE(`RST_VALUE)
         ) u_word (
            .clk_sys(clk_sys),
            .rst_n(rst_ff),
            .wr_sel(sel),
            .wr_be(csr_be),
            .wr_data(csr_wdata),
            .nvm_load(nvm_hit),
            .nvm_data(nvm_load_data),
            .hw_load(hw_hit),
            .hw_data(autoneg_ctrl_value),
            .mirror_load(mir_hit && csr_wdata[0]),
            .mirror_data({word_bus[31:1], csr_wdata[0]}),
            .q_ff(word_bus[32*g +: 32])
         );
      end
   endgenerate

   assign device_control = word_bus[32*I_CTRL +: 32];
   assign extended_device_control = word_bus[32*I_EXT +: 32];
   assign packet_buffer_split = word_bus[32*I_PBA +: 32];
   assign sw_reset = device_control[`CTRL_RESET_BIT];

   // ******************************
   // Clear-on-read cause latch and wide statistic counter
   // ******************************
   reg [31:0] cause_ff;
   reg [STAT_W-1:0] stat_cnt_ff;
   reg [31:0] stat_hi_ff;
   wire cause_rd = csr_req && !csr_wr && is_cause;

   always @(posedge clk_sys or negedge rst_ff)
   begin
      if (!rst_ff)
      begin
         cause_ff <= `RST_VALUE;
      end
      else
      begin
         // Any read clears all bits; new events in same cycle survive
         cause_ff <= (cause_rd ? 32'h00000000 : cause_ff) | cause_set;
      end
   end

   // Counter split in two words; reading low word snapshots high word
   always @(posedge clk_sys or negedge rst_ff)
   begin
      if (!rst_ff)
      begin
         stat_cnt_ff <= {STAT_W{1'b0}};
         stat_hi_ff <= `RST_VALUE;
      end
      else
      begin
         if (stat_event)
         begin
            stat_cnt_ff <= stat_cnt_ff + {{(STAT_W-1){1'b0}}, 1'b1};
         end
         if (csr_req && !csr_wr && acc_idx == 6'd34)
         begin
            stat_hi_ff <= stat_cnt_ff[63:32];
         end
      end
   end

   // ******************************
   // CSR answer
   // ******************************
   reg [31:0] nxt_rdata;

   always @*
   begin
      // Byte enables ignored on reads; whole dword returned
      nxt_rdata = `RD_UNMAPPED;
      if (is_state)
      begin
         nxt_rdata = `RST_VALUE;
         nxt_rdata[`STATE_LINK_BIT] = link_up;
         nxt_rdata[`STATE_NVM_BIT] = nvm_present;
      end
      else if (is_cause)
      begin
         nxt_rdata = cause_ff;
      end
      else if (acc_idx == 6'd34)
      begin
         nxt_rdata = stat_cnt_ff[31:0];
      end
      else if (acc_idx == 6'd35)
      begin
         nxt_rdata = stat_hi_ff;
      end
      else if (acc_idx != I_NONE)
      begin
         nxt_rdata = word_bus[32*acc_idx +: 32];
      end
   end

   always @(posedge clk_sys or negedge rst_ff)
   begin
      if (!rst_ff)
      begin
         csr_ack_ff <= 1'b0;
         csr_rdata_ff <= `RST_VALUE;
      end
      else
      begin
         csr_ack_ff <= csr_req;
         if (csr_req && !csr_wr)
         begin
            csr_rdata_ff <= nxt_rdata;
         end
      end
   end

   // ******************************
   // Flash window
   // ******************************
   function lanes_ok;
      input [1:0] lo;
      input [3:0] be;
      begin
         if (be == 4'hF) lanes_ok = (lo == 2'h0);
         else if (be == 4'h3) lanes_ok = (lo == 2'h0);
         else if (be == 4'hC) lanes_ok = (lo == 2'h2);
         else if (be == 4'h1) lanes_ok = (lo == 2'h0);
         else if (be == 4'h2) lanes_ok = (lo == 2'h1);
         else if (be == 4'h4) lanes_ok = (lo == 2'h2);
         else if (be == 4'h8) lanes_ok = (lo == 2'h3);
         else lanes_ok = 1'b0;
      end
   endfunction

   reg flash_busy_ff;
   wire flash_ok = lanes_ok(flash_addr[1:0], flash_be);

   always @(posedge clk_sys or negedge rst_ff)
   begin
      if (!rst_ff)
      begin
         flash_busy_ff <= 1'b0;
         flash_ack_ff <= 1'b0;
         flash_rdata_ff <= `RST_VALUE;
         flash_cmd_ff <= 1'b0;
         flash_cmd_wr_ff <= 1'b0;
         flash_cmd_addr_ff <= 24'h000000;
         flash_cmd_be_ff <= 4'h0;
         flash_cmd_data_ff <= `RST_VALUE;
      end
      else
      begin
         flash_cmd_ff <= 1'b0;
         flash_ack_ff <= 1'b0;
         if (!flash_busy_ff && flash_req)
         begin
            if (flash_ok)
            begin
               // Byte, word or dword sizes all accepted
               flash_cmd_ff <= 1'b1;
               flash_cmd_wr_ff <= flash_wr;
               flash_cmd_addr_ff <= flash_addr;
               flash_cmd_be_ff <= flash_be;
               flash_cmd_data_ff <= flash_wdata;
               flash_busy_ff <= 1'b1;
            end
            else
            begin
               flash_ack_ff <= 1'b1;
               flash_rdata_ff <= `RD_UNMAPPED;
            end
         end
         else if (flash_busy_ff && flash_rsp_valid)
         begin
            flash_busy_ff <= 1'b0;
            flash_ack_ff <= 1'b1;
            flash_rdata_ff <= flash_rsp_data;
         end
      end
   end

endmodule // csr_access_conventions_map

`default_nettype wire

//--- testbench/flash_engine_model.sv
// Behavioural flash engine answering the block's flash commands
`timescale 1ns/1ns
`default_nettype none
module flash_engine_model
(
   input wire logic clk_sys,
   input wire logic [2:0] lat,
   input wire logic flash_cmd_ff,
   input wire logic [23:0] flash_cmd_addr_ff,
   output var logic flash_rsp_valid,
   output var logic [31:0] flash_rsp_data
);
logic [3:0] cnt;
logic [23:0] addr_ff;
initial
begin
   cnt = 4'h0;
   addr_ff = 24'h000000;
   flash_rsp_valid = 1'b0;
   flash_rsp_data = 32'h00000000;
end
// Data toggles between answers so a stale read shows
always @(posedge clk_sys)
begin
   flash_rsp_valid <= 1'b0;
   flash_rsp_data <= ~flash_rsp_data;
   if (flash_cmd_ff)
   begin
      addr_ff <= flash_cmd_addr_ff;
      cnt <= {1'b0, lat} + 4'h1;
   end
   else if (cnt == 4'h1)
   begin
      flash_rsp_valid <= 1'b1;
      flash_rsp_data <= {8'h5A, addr_ff};
      cnt <= 4'h0;
   end
   else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
end
endmodule // flash_engine_model
`default_nettype wire

//--- testbench/csr_map_props.sv
// Concurrent checks on the CSR map ports
`timescale 1ns/1ns
`default_nettype none
module csr_map_props
#(
   parameter ADDR_W = 17,
   parameter STAT_W = 64
)
(
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic csr_req,
   input wire logic csr_wr,
   input wire logic [ADDR_W-1:0] csr_addr,
   input wire logic [3:0] csr_be,
   input wire logic [31:0] csr_wdata,
   input wire logic csr_ack_ff,
   input wire logic [31:0] csr_rdata_ff,
   input wire logic flash_req,
   input wire logic flash_ack_ff,
   input wire logic flash_cmd_ff,
   input wire logic flash_rsp_valid,
   input wire logic nvm_load_valid,
   input wire logic autoneg_done,
   input wire logic [31:0] autoneg_ctrl_value,
   input wire logic link_up,
   input wire logic nvm_present,
   input wire logic [31:0] device_control,
   input wire logic [31:0] extended_device_control
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!arst_n);
sequence s_quiet;
   !nvm_load_valid && !autoneg_done;
endsequence
sequence s_wr(a, full);
   csr_req && csr_wr && csr_addr == a && ((csr_be == 4'hF) == full) ##0 s_quiet;
endsequence
property p_ack; csr_req |=> csr_ack_ff; endproperty
a_ack: assert property (p_ack) else $error("no ack after request");
property p_ack_cause; csr_ack_ff |-> $past(csr_req); endproperty
a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
property p_full_wr; s_wr(17'h0, 1'b1) |=> device_control == $past(csr_wdata); endproperty
a_full_wr: assert property (p_full_wr) else $error("dword write lost");
property p_part_wr; s_wr(17'h0, 1'b0) |=> $stable(device_control); endproperty
a_part_wr: assert property (p_part_wr) else $error("partial write took effect");
property p_part_rd;
   csr_req && !csr_wr && csr_addr == 17'h0 && csr_be != 4'hF |=> csr_rdata_ff == $past(device_control);
endproperty
a_part_rd: assert property (p_part_rd) else $error("partial read not full word");
property p_state;
   csr_req && !csr_wr && csr_addr == 17'h8 |=> csr_rdata_ff[1] == $past(link_up) && csr_rdata_ff[8] == $past(nvm_present);
endproperty
a_state: assert property (p_state) else $error("status bits wrong");
property p_autoneg; autoneg_done && !nvm_load_valid |=> device_control == $past(autoneg_ctrl_value); endproperty
a_autoneg: assert property (p_autoneg) else $error("autoneg value not loaded");
property p_mirror;
   s_wr(17'h18, 1'b1) ##0 csr_wdata[0] |=> device_control[0] && extended_device_control == $past(csr_wdata);
endproperty
a_mirror: assert property (p_mirror) else $error("mirror bit not reflected");
property p_flash_ack; flash_rsp_valid |=> flash_ack_ff; endproperty
a_flash_ack: assert property (p_flash_ack) else $error("flash answer not acked");
property p_flash_cmd; flash_cmd_ff |-> $past(flash_req); endproperty
a_flash_cmd: assert property (p_flash_cmd) else $error("flash command without request");
endmodule // csr_map_props
bind csr_access_conventions_map csr_map_props #(.ADDR_W(ADDR_W), .STAT_W(STAT_W)) i_csr_map_props (
   .clk_sys(clk_sys), .arst_n(arst_n), .csr_req(csr_req), .csr_wr(csr_wr), .csr_addr(csr_addr),
   .csr_be(csr_be), .csr_wdata(csr_wdata), .csr_ack_ff(csr_ack_ff), .csr_rdata_ff(csr_rdata_ff),
   .flash_req(flash_req), .flash_ack_ff(flash_ack_ff), .flash_cmd_ff(flash_cmd_ff),
   .flash_rsp_valid(flash_rsp_valid), .nvm_load_valid(nvm_load_valid), .autoneg_done(autoneg_done),
   .autoneg_ctrl_value(autoneg_ctrl_value), .link_up(link_up), .nvm_present(nvm_present),
   .device_control(device_control), .extended_device_control(extended_device_control));
`default_nettype wire

//--- testbench/csr_access_conventions_map_tb.sv
// Self-checking bench for the CSR map
`timescale 1ns/1ns
`default_nettype none
module csr_access_conventions_map_tb;
typedef struct packed {logic chk; logic [31:0] exp; logic [31:0] msk;} note_t;
logic clk_sys = 1'b0;
logic arst_n, csr_req, csr_wr, flash_req, flash_wr, flash_rsp_valid, nvm_load_valid, autoneg_done;
logic link_up, nvm_present, stat_event, csr_ack_ff, flash_ack_ff, flash_cmd_ff, flash_cmd_wr_ff, sw_reset;
logic [16:0] csr_addr, nvm_load_addr;
logic [3:0] csr_be, flash_be, flash_cmd_be_ff;
logic [23:0] flash_addr, flash_cmd_addr_ff;
logic [2:0] lat;
logic [31:0] csr_wdata, csr_rdata_ff, flash_wdata, flash_rdata_ff, flash_cmd_data_ff, flash_rsp_data, v;
logic [31:0] nvm_load_data, autoneg_ctrl_value, cause_set, device_control, extended_device_control, packet_buffer_split;
int error_cnt = 0, n_checks = 0, cyc = 0, n;
note_t cq[$], fq[$], cn, fn;
logic [31:0] wv[28];
logic [16:0] rw_ofs[28] = '{17'h0, 17'h14, 17'h18, 17'h1C, 17'h20, 17'h28, 17'h2C, 17'h30, 17'h38, 17'h170,
   17'hE00, 17'hF00, 17'hF08, 17'h1000, 17'h1028, 17'h102C, 17'h1030, 17'h1034, 17'h1038, 17'h103C,
   17'h1050, 17'h5B00, 17'h5B08, 17'h5B10, 17'h5B14, 17'h5B18, 17'h5B1C, 17'h5F40};
logic [3:0] pbe[9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'h7, 4'hE, 4'h0};
logic [3:0] lanes[7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF};
logic [1:0] offs[7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h2, 2'h0};
always #4 clk_sys = ~clk_sys;
csr_access_conventions_map i_csr_access_conventions_map (.clk_sys(clk_sys), .arst_n(arst_n),
   .csr_req(csr_req), .csr_wr(csr_wr), .csr_addr(csr_addr), .csr_be(csr_be), .csr_wdata(csr_wdata),
   .csr_ack_ff(csr_ack_ff), .csr_rdata_ff(csr_rdata_ff), .flash_req(flash_req), .flash_wr(flash_wr),
   .flash_addr(flash_addr), .flash_be(flash_be), .flash_wdata(flash_wdata), .flash_ack_ff(flash_ack_ff),
   .flash_rdata_ff(flash_rdata_ff), .flash_cmd_ff(flash_cmd_ff), .flash_cmd_wr_ff(flash_cmd_wr_ff),
   .flash_cmd_addr_ff(flash_cmd_addr_ff), .flash_cmd_be_ff(flash_cmd_be_ff),
   .flash_cmd_data_ff(flash_cmd_data_ff), .flash_rsp_valid(flash_rsp_valid), .flash_rsp_data(flash_rsp_data),
   .nvm_load_valid(nvm_load_valid), .nvm_load_addr(nvm_load_addr), .nvm_load_data(nvm_load_data),
   .autoneg_done(autoneg_done), .autoneg_ctrl_value(autoneg_ctrl_value), .link_up(link_up),
   .nvm_present(nvm_present), .cause_set(cause_set), .stat_event(stat_event), .device_control(device_control),
   .extended_device_control(extended_device_control), .packet_buffer_split(packet_buffer_split),
   .sw_reset(sw_reset));
flash_engine_model i_flash_engine_model (.clk_sys(clk_sys), .lat(lat), .flash_cmd_ff(flash_cmd_ff),
   .flash_cmd_addr_ff(flash_cmd_addr_ff), .flash_rsp_valid(flash_rsp_valid), .flash_rsp_data(flash_rsp_data));
// ****************
// Shared tasks
// ****************
task automatic check(input logic [31:0] seen, input logic [31:0] exp);
   n_checks++;
   if (seen !== exp)
   begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
   end
endtask
task automatic end_sim();
   // Unanswered requests count as lost results
   if (cq.size() > 0 || fq.size() > 0)
      error_cnt++;
   $display("checks %0d mismatches %0d", n_checks, error_cnt);
   if (error_cnt == 0 && n_checks > 0)
      $display("DONE - PASS");
   else
      $display("DONE - FAIL");
   $finish;
endtask
task automatic op(input logic w, input logic [16:0] a, input logic [3:0] be, input logic [31:0] d, input note_t nt);
   @(posedge clk_sys);
   csr_req <= 1'b1;
   csr_wr <= w;
   csr_addr <= a;
   csr_be <= be;
   csr_wdata <= d;
   cq.push_back(nt);
endtask
task automatic rd(input logic [16:0] a, input logic [3:0] be, input logic [31:0] e, input logic [31:0] m);
   op(1'b0, a, be, $urandom, '{1'b1, e, m});
endtask
task automatic wr(input logic [16:0] a, input logic [3:0] be, input logic [31:0] d);
   op(1'b1, a, be, d, '{1'b0, 32'h0, 32'h0});
endtask
task automatic idle();
   @(posedge clk_sys);
   csr_req <= 1'b0;
endtask
task automatic fl(input logic w, input logic [23:0] a, input logic [3:0] be, input logic ok);
   logic [31:0] d;
   d = $urandom;
   fq.push_back('{~w, ok ? {8'h5A, a} : 32'h0, 32'hFFFFFFFF});
   @(posedge clk_sys);
   flash_req <= 1'b1;
   flash_wr <= w;
   flash_addr <= a;
   flash_be <= be;
   flash_wdata <= d;
   lat <= 3'($urandom % 6);
   @(posedge clk_sys);
   flash_req <= 1'b0;
   for (int k = 0; k < 40 && flash_ack_ff !== 1'b1; k++)
      @(posedge clk_sys);
   // Command fields hold after the access
   if (ok)
   begin
      check({flash_cmd_wr_ff, flash_cmd_be_ff, 3'h0, flash_cmd_addr_ff}, {w, be, 3'h0, a});
      check(flash_cmd_data_ff, d);
   end
   @(posedge clk_sys);
endtask
// ****************
// Result monitor
// ****************
always @(posedge clk_sys)
begin
   if (csr_ack_ff === 1'b1 && cq.size() > 0)
   begin
      cn = cq.pop_front();
      if (cn.chk)
         check(csr_rdata_ff & cn.msk, cn.exp & cn.msk);
   end
   else if (csr_ack_ff === 1'b1)
      error_cnt++;
   if (flash_ack_ff === 1'b1 && fq.size() > 0)
   begin
      fn = fq.pop_front();
      if (fn.chk)
         check(flash_rdata_ff, fn.exp);
   end
   else if (flash_ack_ff === 1'b1)
      error_cnt++;
end
always @(posedge clk_sys)
begin
   cyc++;
   if (cyc == 3000)
   begin
      error_cnt++;
      end_sim();
   end
end
// ****************
// Main sequence
// ****************
initial
begin
   {arst_n, csr_req, csr_wr, flash_req, flash_wr, nvm_load_valid, autoneg_done, stat_event, nvm_present} = '0;
   {csr_addr, csr_be, csr_wdata, flash_addr, flash_be, flash_wdata, nvm_load_addr, nvm_load_data} = '0;
   {autoneg_ctrl_value, cause_set, lat} = '0;
   link_up = 1'b1;
   v = $urandom(32'h1fb43239);
   repeat (4) @(posedge clk_sys);
   arst_n <= 1'b1;
   repeat (3) @(posedge clk_sys);
   rd(17'h0, 4'hF, 32'h0, 32'hFFFFFFFF);
   rd(17'h8, 4'h1, 32'h2, 32'h102);
   rd(17'hF04, 4'hF, 32'h0, 32'hFFFFFFFF);
   for (int i = 0; i < 28; i++)
   begin
      wv[i] = $urandom & 32'hFBFFFFFE;
      wr(rw_ofs[i], 4'hF, wv[i]);
   end
   for (int i = 0; i < 28; i++)
      rd(rw_ofs[i], 4'hF, wv[i], 32'hFFFFFFFF);
   foreach (pbe[i])
      wr(17'h0, pbe[i], ~wv[0]);
   rd(17'h0, 4'h3, wv[0], 32'hFFFFFFFF);
   wr(17'h1014, 4'hF, 32'hFFFFFFFF);
   rd(17'h1014, 4'hF, 32'h0, 32'hFFFFFFFF);
   idle();
   $display("test register bank done");
   v = $urandom & 32'hFBFFFFFF;
   nvm_load_valid <= 1'b1;
   nvm_load_addr <= 17'h1014;
   nvm_load_data <= v;
   @(posedge clk_sys);
   nvm_load_valid <= 1'b0;
   autoneg_done <= 1'b1;
   autoneg_ctrl_value <= ~v & 32'hFBFFFFFF;
   @(posedge clk_sys);
   autoneg_done <= 1'b0;
   rd(17'h1014, 4'hF, v, 32'hFFFFFFFF);
   rd(17'h0, 4'hF, ~v & 32'hFBFFFFFF, 32'hFFFFFFFF);
   wr(17'h18, 4'hF, 32'h1);
   rd(17'h0, 4'hF, 32'h1, 32'h1);
   rd(17'h4, 4'hF, (~v & 32'hFBFFFFFF) | 32'h1, 32'hFFFFFFFF);
   idle();
   cause_set <= 32'h81;
   @(posedge clk_sys);
   cause_set <= 32'h0;
   rd(17'hC0, 4'h1, 32'h81, 32'hFFFFFFFF);
   rd(17'hC0, 4'hF, 32'h0, 32'hFFFFFFFF);
   idle();
   n = 1 + $urandom % 20;
   stat_event <= 1'b1;
   repeat (n) @(posedge clk_sys);
   stat_event <= 1'b0;
   rd(17'h5B20, 4'hF, 32'(n), 32'hFFFFFFFF);
   rd(17'h5B24, 4'hF, 32'h0, 32'hFFFFFFFF);
   idle();
   nvm_present <= 1'b1;
   link_up <= 1'b0;
   wr(17'h0, 4'hF, 32'h04000000);
   rd(17'h8, 4'hF, 32'h100, 32'h102);
   idle();
   check({31'h0, sw_reset}, 32'h1);
   check(packet_buffer_split, wv[13]);
   $display("test superseding and counters done");
   foreach (lanes[i])
      fl(1'b0, {22'h0A5C3, offs[i]}, lanes[i], 1'b1);
   fl(1'b0, 24'h000101, 4'h3, 1'b0);
   fl(1'b1, 24'h000202, 4'h4, 1'b1);
   $display("test flash sizes done");
   repeat (4) @(posedge clk_sys);
   end_sim();
end
endmodule // csr_access_conventions_map_tb
`default_nettype wire
